// ### rtl/dsp_status_prio.sv
/*
 * DMA status flags, error interrupt, general output register and
 * channel arbitration with preemption, behind an APB slave.
 * Assumes the transfer engine pulses its events for one cycle and holds
 * channel requests until served; APB master follows the usual protocol.
 */
// Our own choices: the APB interface to the registers and the register addresses.
module dsp_status_prio
	import dsp_pkg::*;
#(
	parameter int NUM_CH = MAX_CH
)
(
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [ADDR_W-1:0]  paddr,
	input  wire logic [DATA_W-1:0]  pwdata,
	output logic      [DATA_W-1:0]  prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic [MAX_CH-1:0]  done_irq_evt,
	input  wire logic [MAX_CH-1:0]  err_evt,
	input  wire logic [MAX_CH-1:0]  chan_req,
	input  wire logic               seq_done,
	input  wire logic               minor_done,
	output logic      [MAX_CH-1:0]  irq_req,
	output logic                    err_irq,
	output logic      [DATA_W-1:0]  gpo_word,
	output dsp_gpo_s                gpo,
	output dsp_grant_s              grant,
	output logic                    config_err
);

	if (NUM_CH < 2 || NUM_CH > MAX_CH)
	begin : g_bad_num_ch
		$error("NUM_CH must lie between 2 and 16");
	end

	localparam logic [MAX_CH-1:0] IMPL_MASK = MAX_CH'((33'h1 << NUM_CH) - 33'h1);

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic      [MAX_CH-1:0] irq_pend_r;
	logic      [MAX_CH-1:0] err_flags_r;
	logic      [MAX_CH-1:0] err_en_r;
	logic      [DATA_W-1:0] gpo_r;
	logic                   rr_mode_r;
	dsp_prio_s              prio_r [NUM_CH];
	dsp_arb_e               state_r;
	logic      [CH_W-1:0]   act_ch_r;
	logic      [CH_W-1:0]   susp_ch_r;
	logic      [CH_W-1:0]   rr_last_r;
	logic                   config_err_r;
	logic      [DATA_W-1:0] prdata_r;

	////////////////////////////////////////////////////////////////////////
	// APB decode
	logic                   acc;
	logic                   wr_en;
	logic                   hit;
	logic      [DATA_W-1:0] rd_val;
	logic                   prio_sel;
	logic      [CH_W-1:0]   prio_idx;

	assign acc      = psel && penable;
	assign prio_sel = (paddr >= OFS_PRIO_BASE)
		&& (int'(paddr - OFS_PRIO_BASE) < NUM_CH * 4);
	assign prio_idx = CH_W'((paddr - OFS_PRIO_BASE) >> PRIO_IDX_LSB);

	always_comb
	begin
		hit    = 1'b1;
		rd_val = '0;
		if (paddr[1:0] != 2'h0)
			hit = 1'b0;
		else if (prio_sel)
			rd_val = {24'h00_0000, prio_r[prio_idx]};
		else
		begin
			unique case (paddr)
				OFS_IRQ_PEND:  rd_val = {16'h0000, irq_pend_r};
				OFS_ERR_FLAGS: rd_val = {16'h0000, err_flags_r};
				OFS_ERR_EN:    rd_val = {16'h0000, err_en_r};
				OFS_IRQ_CLR:   rd_val = '0;
				OFS_ERR_CLR:   rd_val = '0;
				OFS_GPO:       rd_val = gpo_r;
				OFS_ENG_CTRL:  rd_val = DATA_W'(rr_mode_r);
				OFS_ARB_STAT:  rd_val = DATA_W'({config_err_r, 4'h0, grant.suspended,
						2'h0, grant.preempting, grant.valid, grant.channel});
				default:       hit    = 1'b0;
			endcase
		end
	end

	assign wr_en   = acc && pwrite && hit;
	assign pready  = 1'b1;
	assign pslverr = acc && !hit;
	assign prdata  = prdata_r;

	// Read data caught in the setup cycle so the answer needs no wait state
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			prdata_r <= '0;
		else if (psel && !penable && !pwrite)
			prdata_r <= rd_val;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt pending flags
	logic [MAX_CH-1:0] irq_clr;
	logic [MAX_CH-1:0] irq_pend_nxt;

	always_comb
	begin
		irq_clr = '0;
		if (wr_en && paddr == OFS_IRQ_PEND)
			irq_clr = pwdata[MAX_CH-1:0];
		if (wr_en && paddr == OFS_IRQ_CLR)
			irq_clr = cmd_mask(pwdata[7:0]);
		irq_pend_nxt = ((irq_pend_r & ~irq_clr) | done_irq_evt) & IMPL_MASK;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq_pend_r <= FLAGS_RST;
		else
			irq_pend_r <= irq_pend_nxt;
	end

	assign irq_req = irq_pend_r;

	////////////////////////////////////////////////////////////////////////
	// Error flags and error interrupt
	logic [MAX_CH-1:0] err_clr;
	logic [MAX_CH-1:0] err_flags_nxt;

	always_comb
	begin
		err_clr = '0;
		if (wr_en && paddr == OFS_ERR_FLAGS)
			err_clr = pwdata[MAX_CH-1:0];
		if (wr_en && paddr == OFS_ERR_CLR)
			err_clr = cmd_mask(pwdata[7:0]);
		// set wins; kept apart from pending flags
		err_flags_nxt = ((err_flags_r & ~err_clr) | err_evt) & IMPL_MASK;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			err_flags_r <= FLAGS_RST;
		else
			err_flags_r <= err_flags_nxt;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			err_en_r <= FLAGS_RST;
		else if (wr_en && paddr == OFS_ERR_EN)
			err_en_r <= pwdata[MAX_CH-1:0] & IMPL_MASK;
	end

	assign err_irq = |(err_flags_r & err_en_r);

	////////////////////////////////////////////////////////////////////////
	// General output and engine control
	// writable, driven out
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			gpo_r <= GPO_RST;
		else if (wr_en && paddr == OFS_GPO)
			gpo_r <= pwdata & GPO_WR_MASK;
	end

	assign gpo_word = gpo_r;
	assign gpo.bus_high_priority = gpo_r[GPO_PRIO_BIT];
	assign gpo.snoop_enable      = gpo_r[GPO_SNOOP_BIT];
	assign gpo.ignore_bus_errors = gpo_r[GPO_ERRDIS_BIT];
	assign gpo.read_safe         = gpo_r[GPO_RDSAFE_BIT];

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rr_mode_r <= 1'b0;
		else if (wr_en && paddr == OFS_ENG_CTRL)
			rr_mode_r <= pwdata[CTRL_RR_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// Channel priority configuration
	// Reset ranks are distinct so arbitration is legal out of reset
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NUM_CH; i++)
				prio_r[i] <= '{1'b0, 1'b0, GROUP_LEVEL, CH_W'(i)};
		end
		else if (wr_en && prio_sel)
		begin
			prio_r[prio_idx] <= (pwdata[7:0] & PRIO_WR_MASK) | {2'h0, GROUP_LEVEL, 4'h0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Arbitration
	logic [NUM_CH-1:0][CH_W-1:0] ranks;
	logic [NUM_CH-1:0]           forbid_vec;
	logic [NUM_CH-1:0]           pre_req;
	logic                        win_found;
	logic [CH_W-1:0]             win_ch;
	logic                        dup_rank;
	logic                        pre_found;
	logic [CH_W-1:0]             pre_ch;
	logic                        do_preempt;
	logic [MAX_CH-1:0]           act_bit;

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			ranks[i]      = prio_r[i].channel_rank;
			forbid_vec[i] = prio_r[i].forbid_suspending_others;
		end
	end

	// forbidding channels never compete to suspend
	assign act_bit = ch_bit(act_ch_r);
	assign pre_req = chan_req[NUM_CH-1:0] & ~forbid_vec & ~act_bit[NUM_CH-1:0];

	dsp_rank_pick #(.NUM_CH(NUM_CH)) u_win_pick
	(
		.req      (chan_req[NUM_CH-1:0]),
		.rank     (ranks),
		.rr_mode  (rr_mode_r),
		.rr_last  (rr_last_r),
		.found    (win_found),
		.pick     (win_ch),
		.dup_rank (dup_rank)
	);

	dsp_rank_pick #(.NUM_CH(NUM_CH)) u_pre_pick
	(
		.req      (pre_req),
		.rank     (ranks),
		.rr_mode  (1'b0),
		.rr_last  (rr_last_r),
		.found    (pre_found),
		.pick     (pre_ch),
		.dup_rank ()
	);

	// only fixed mode and a preemptible running channel
	assign do_preempt = !rr_mode_r && state_r == ARB_RUN && !minor_done
		&& prio_r[act_ch_r].allow_being_suspended && pre_found
		&& ranks[pre_ch] > ranks[act_ch_r];

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r   <= ARB_IDLE;
			act_ch_r  <= '0;
			susp_ch_r <= '0;
			rr_last_r <= '0;
		end
		else
		begin
			unique case (state_r)
				ARB_IDLE:
					if (win_found)
					begin
						state_r   <= ARB_RUN;
						act_ch_r  <= win_ch;
						rr_last_r <= win_ch;
					end
				ARB_RUN:
					if (minor_done)
						state_r <= ARB_IDLE;
					else if (do_preempt)
					begin
						state_r   <= ARB_PREEMPT;
						susp_ch_r <= act_ch_r;
						act_ch_r  <= pre_ch;
					end
				ARB_PREEMPT:
					if (minor_done)
					begin
						state_r  <= ARB_RESUME;
						act_ch_r <= susp_ch_r;
					end
				ARB_RESUME:
					if (minor_done)
						state_r <= ARB_IDLE;
					else if (seq_done)
						state_r <= ARB_RUN;
			endcase
		end
	end

	// report duplicate ranks in fixed mode
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			config_err_r <= 1'b0;
		else
			config_err_r <= dup_rank && !rr_mode_r;
	end

	assign config_err       = config_err_r;
	assign grant.valid      = state_r != ARB_IDLE;
	assign grant.channel    = act_ch_r;
	assign grant.preempting = state_r == ARB_PREEMPT;
	assign grant.suspended  = susp_ch_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence s_preempt_entry;
		state_r == ARB_RUN && do_preempt;
	endsequence

	sequence s_preempt_end;
		state_r == ARB_PREEMPT && minor_done;
	endsequence

	a_irq_set_seen: assert property (
		done_irq_evt != '0 |=>
			(irq_pend_r & $past(done_irq_evt & IMPL_MASK)) == $past(done_irq_evt & IMPL_MASK))
		else $error("completion event lost");

	a_irq_rise_cause: assert property (
		((irq_req & ~$past(irq_req)) & ~$past(done_irq_evt)) == '0)
		else $error("interrupt output rose without completion");

	a_irq_w1c_clear: assert property (
		wr_en && paddr == OFS_IRQ_PEND && done_irq_evt == '0 |=>
			(irq_pend_r & $past(pwdata[MAX_CH-1:0])) == '0)
		else $error("pending bit not cleared by write");

	a_irq_cmd_all: assert property (
		wr_en && paddr == OFS_IRQ_CLR && pwdata[7:6] == 2'b01 && done_irq_evt == '0
			|=> irq_pend_r == '0)
		else $error("clear-all command failed");

	a_err_irq_raise: assert property (
		(err_evt & err_en_r & IMPL_MASK) != '0 && !(wr_en && paddr == OFS_ERR_EN)
			|=> err_irq)
		else $error("enabled error did not raise interrupt");

	a_err_w1c_clear: assert property (
		wr_en && paddr == OFS_ERR_FLAGS && err_evt == '0 |=>
			(err_flags_r & $past(pwdata[MAX_CH-1:0])) == '0)
		else $error("error flag not cleared by write");

	a_err_cmd_one: assert property (
		wr_en && paddr == OFS_ERR_CLR && pwdata[7:4] == 4'h0 && err_evt == '0 |=>
			!err_flags_r[$past(pwdata[3:0])])
		else $error("single error clear failed");

	a_preempt_swap: assert property (
		s_preempt_entry |=> state_r == ARB_PREEMPT && susp_ch_r == $past(act_ch_r))
		else $error("preemption did not save running channel");

	a_resume_restore: assert property (
		s_preempt_end |=> state_r == ARB_RESUME && act_ch_r == $past(susp_ch_r))
		else $error("suspended channel not resumed");

	a_resume_guard: assert property (
		state_r == ARB_RESUME && !seq_done && !minor_done |=> state_r == ARB_RESUME)
		else $error("resumed channel left before one sequence");

	a_no_nesting: assert property (
		state_r == ARB_PREEMPT && !minor_done |=>
			state_r == ARB_PREEMPT && $stable(act_ch_r))
		else $error("preempting channel was preempted");

	a_rr_no_suspend: assert property (
		rr_mode_r && state_r != ARB_PREEMPT |=> state_r != ARB_PREEMPT)
		else $error("preemption in round-robin mode");

	a_forbid_honoured: assert property (
		state_r == ARB_RUN ##1 state_r == ARB_PREEMPT |->
			!forbid_vec[act_ch_r] || $past(wr_en && prio_sel))
		else $error("forbidding channel suspended another");

endmodule : dsp_status_prio

// ### rtl/dsp_pkg.sv
/*
 * Shared constants, types and helpers of the DMA status, output and
 * channel priority block. Assumes one APB slave window of 256 bytes.
 */
package dsp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sizes
	localparam int MAX_CH = 16;
	localparam int CH_W   = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_IRQ_PEND  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ERR_FLAGS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ERR_EN    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR   = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_ERR_CLR   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_GPO       = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_ENG_CTRL  = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_ARB_STAT  = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 8'h40;
	localparam int                PRIO_IDX_LSB  = 2;

	////////////////////////////////////////////////////////////////////////
	// Field positions and masks
	localparam int CMD_IGNORE_BIT  = 7;
	localparam int CMD_ALL_BIT     = 6;
	localparam int GPO_PRIO_BIT    = 12;
	localparam int GPO_SNOOP_BIT   = 6;
	localparam int GPO_ERRDIS_BIT  = 4;
	localparam int GPO_RDSAFE_BIT  = 2;
	localparam int CTRL_RR_BIT     = 0;
	localparam int STAT_VALID_BIT  = 4;
	localparam int STAT_PREEMPT_BIT = 5;
	localparam int STAT_SUSP_LSB   = 8;
	localparam int STAT_CFGERR_BIT = 16;

	localparam logic [DATA_W-1:0] GPO_WR_MASK = 32'h0000_1054;
	localparam logic [DATA_W-1:0] GPO_RST     = 32'h0000_0000;
	localparam logic [7:0]        PRIO_WR_MASK = 8'hCF;
	localparam logic [1:0]        GROUP_LEVEL  = 2'h0;
	localparam logic [MAX_CH-1:0] FLAGS_RST    = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0]
	{
		ARB_IDLE    = 2'b00,
		ARB_RUN     = 2'b01,
		ARB_PREEMPT = 2'b10,
		ARB_RESUME  = 2'b11
	} dsp_arb_e;

	typedef struct packed
	{
		logic            allow_being_suspended;
		logic            forbid_suspending_others;
		logic [1:0]      group_rank;
		logic [CH_W-1:0] channel_rank;
	} dsp_prio_s;

	typedef struct packed
	{
		logic bus_high_priority;
		logic snoop_enable;
		logic ignore_bus_errors;
		logic read_safe;
	} dsp_gpo_s;

	typedef struct packed
	{
		logic            valid;
		logic [CH_W-1:0] channel;
		logic            preempting;
		logic [CH_W-1:0] suspended;
	} dsp_grant_s;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [MAX_CH-1:0] ch_bit(input logic [CH_W-1:0] ch);
		ch_bit = 16'h0001 << ch;
	endfunction : ch_bit

	// Byte command: bit 7 ignores, 0..15 one channel, 64..127 all
	function automatic logic [MAX_CH-1:0] cmd_mask(input logic [7:0] cmd);
		if (cmd[CMD_IGNORE_BIT])
			cmd_mask = 16'h0000;
		else if (cmd[CMD_ALL_BIT])
			cmd_mask = 16'hFFFF;
		else if (cmd[5:4] == 2'h0)
			cmd_mask = ch_bit(cmd[CH_W-1:0]);
		else
			cmd_mask = 16'h0000;
	endfunction : cmd_mask

endpackage : dsp_pkg

// ### rtl/dsp_rank_pick.sv
/*
 * Combinational channel picker: highest rank in fixed mode, next after
 * the last grant in round-robin mode, plus a duplicate-rank detector.
 * Assumes request and rank vectors are stable within a cycle.
 */
module dsp_rank_pick
	import dsp_pkg::*;
#(
	parameter int NUM_CH = MAX_CH
)
(
	input  wire logic [NUM_CH-1:0]           req,
	input  wire logic [NUM_CH-1:0][CH_W-1:0] rank,
	input  wire logic                        rr_mode,
	input  wire logic [CH_W-1:0]             rr_last,
	output logic                             found,
	output logic [CH_W-1:0]                  pick,
	output logic                             dup_rank
);

	always_comb
	begin
		int idx;
		idx      = 0;
		found    = 1'b0;
		pick     = '0;
		dup_rank = 1'b0;
		if (rr_mode)
		begin
			for (int k = 1; k <= NUM_CH; k++)
			begin
				idx = (int'(rr_last) + k) % NUM_CH;
				if (!found && req[idx])
				begin
					found = 1'b1;
					pick  = CH_W'(idx);
				end
			end
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				if (req[i] && (!found || rank[i] > rank[pick]))
				begin
					found = 1'b1;
					pick  = CH_W'(i);
				end
			end
		end
		for (int i = 0; i < NUM_CH; i++)
		begin
			for (int j = i + 1; j < NUM_CH; j++)
			begin
				if (rank[i] == rank[j])
					dup_rank = 1'b1;
			end
		end
	end

endmodule : dsp_rank_pick

// ### verification/dsp_engine_model.sv
/*
 * Stand-in for the transfer engine beside the status block.
 * Assumes the bench calls its tasks from one thread, at falling edges.
 */
module dsp_engine_model
	import dsp_pkg::*;
(
	input  wire logic         clk_sys,
	output logic [MAX_CH-1:0] done_irq_evt,
	output logic [MAX_CH-1:0] err_evt,
	output logic [MAX_CH-1:0] chan_req,
	output logic              seq_done,
	output logic              minor_done
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		{done_irq_evt, err_evt, chan_req, seq_done, minor_done} = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Events last one cycle, like the real engine
	task automatic pulse(input logic [MAX_CH-1:0] d, input logic [MAX_CH-1:0] e,
		input logic s, input logic m);
		@(posedge clk_sys);
		done_irq_evt <= d;
		err_evt      <= e;
		seq_done     <= s;
		minor_done   <= m;
		@(posedge clk_sys);
		{done_irq_evt, err_evt, seq_done, minor_done} <= '0;
	endtask : pulse

	// Requests are levels held until served
	task automatic request(input logic [MAX_CH-1:0] r);
		@(posedge clk_sys);
		chan_req <= r;
	endtask : request

endmodule : dsp_engine_model

// ### verification/tb.sv
/*
 * Self-checking bench: APB master, flags, general output, arbiter.
 * Tolerates APB wait states; assumes one-cycle engine events per the hand-over.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dsp_pkg::*;

	logic               clk_sys = 1'b0;
	logic               rst_n   = 1'b0;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [ADDR_W-1:0]  paddr;
	logic [DATA_W-1:0]  pwdata;
	logic [DATA_W-1:0]  prdata, gpo_word;
	logic               pready, pslverr, err_irq, config_err, seq_done, minor_done;
	logic [MAX_CH-1:0]  done_irq_evt, err_evt, chan_req, irq_req;
	dsp_gpo_s           gpo;
	dsp_grant_s         grant;
	int                 fails = 0;
	int                 checks = 0;

	always #4 clk_sys = ~clk_sys;

	dsp_status_prio dsp_status_prio_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.done_irq_evt(done_irq_evt), .err_evt(err_evt), .chan_req(chan_req),
		.seq_done(seq_done), .minor_done(minor_done), .irq_req(irq_req),
		.err_irq(err_irq), .gpo_word(gpo_word), .gpo(gpo), .grant(grant),
		.config_err(config_err));

	dsp_engine_model dsp_engine_model_i (.clk_sys(clk_sys), .done_irq_evt(done_irq_evt),
		.err_evt(err_evt), .chan_req(chan_req), .seq_done(seq_done),
		.minor_done(minor_done));

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// Bounded wait on pready; slave latency never assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fails++;
			report_and_stop();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Let the landed write settle before callers look at outputs
		@(negedge clk_sys);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		check(q, exp);
	endtask : rd

	task automatic cyc();
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask : cyc

	task automatic ev(input logic [15:0] d, input logic [15:0] e, input logic s,
		input logic m);
		dsp_engine_model_i.pulse(d, e, s, m);
		@(negedge clk_sys);
	endtask : ev

	// Serve once: request, then drop it as the engine does
	task automatic run(input logic [15:0] r);
		dsp_engine_model_i.request(r);
		dsp_engine_model_i.request(16'h0000);
		@(negedge clk_sys);
	endtask : run

	function automatic logic [31:0] gs();
		return {26'h0, grant.valid, grant.channel, grant.preempting};
	endfunction : gs

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check({irq_req, 13'h0, err_irq, config_err, grant.valid}, 32'h0000_0000);
		check(gpo_word, 32'h0000_0000);
		rd(OFS_PRIO_BASE + 8'h04, 32'h0000_0001);
		$display("reset test done");
	endtask : t_reset

	task automatic t_irq();
		ev(16'h0028, 16'h0000, 1'b0, 1'b0);
		check(32'(irq_req), 32'h0000_0028);
		wr(OFS_IRQ_PEND, 32'hFFFF_0008);
		check(32'(irq_req), 32'h0000_0020);
		wr(OFS_IRQ_CLR, 32'h0000_0085);
		wr(OFS_IRQ_CLR, 32'h0000_0014);
		check(32'(irq_req), 32'h0000_0020);
		wr(OFS_IRQ_CLR, 32'h0000_0005);
		check(32'(irq_req), 32'h0000_0000);
		ev(16'hFFFF, 16'h0000, 1'b0, 1'b0);
		wr(OFS_IRQ_CLR, 32'h0000_007F);
		check(32'(irq_req), 32'h0000_0000);
		rd(OFS_IRQ_CLR, 32'h0000_0000);
		$display("irq test done");
	endtask : t_irq

	task automatic t_err();
		ev(16'h0002, 16'h0006, 1'b0, 1'b0);
		check({err_irq, 15'h0, irq_req}, 32'h0000_0002);
		rd(OFS_ERR_FLAGS, 32'h0000_0006);
		wr(OFS_ERR_EN, 32'h0000_0004);
		check(32'(err_irq), 32'h0000_0001);
		wr(OFS_ERR_FLAGS, 32'h0000_0004);
		check(32'(err_irq), 32'h0000_0000);
		ev(16'h0000, 16'h8004, 1'b0, 1'b0);
		wr(OFS_ERR_CLR, 32'h0000_000F);
		rd(OFS_ERR_FLAGS, 32'h0000_0006);
		wr(OFS_ERR_CLR, 32'h0000_0040);
		rd(OFS_ERR_FLAGS, 32'h0000_0000);
		wr(OFS_IRQ_PEND, 32'h0000_FFFF);
		$display("error test done");
	endtask : t_err

	task automatic t_gpo();
		logic [31:0] q;
		logic        e;
		wr(OFS_GPO, 32'hFFFF_FFFF);
		check(gpo_word, 32'h0000_1054);
		check(32'(gpo), 32'h0000_000F);
		wr(OFS_GPO, 32'h0000_0040);
		check(32'(gpo), 32'h0000_0004);
		rd(OFS_GPO, 32'h0000_0040);
		apb(1'b0, 8'h30, 32'h0000_0000, q, e);
		check(32'(e), 32'h0000_0001);
		$display("output test done");
	endtask : t_gpo

	task automatic t_arb();
		run(16'h0028);
		check(gs(), 32'h0000_002A);
		ev(16'h0000, 16'h0000, 1'b0, 1'b1);
		ev(16'h0000, 16'h0000, 1'b0, 1'b1);
		wr(OFS_PRIO_BASE + 8'h08, 32'h0000_0082);
		run(16'h0004);
		run(16'h0200);
		check(gs(), 32'h0000_0033);
		check(32'(grant.suspended), 32'h0000_0002);
		dsp_engine_model_i.request(16'h1000);
		cyc();
		check(gs(), 32'h0000_0033);
		ev(16'h0000, 16'h0000, 1'b0, 1'b1);
		cyc();
		check(gs(), 32'h0000_0024);
		ev(16'h0000, 16'h0000, 1'b1, 1'b0);
		cyc();
		check(gs(), 32'h0000_0039);
		dsp_engine_model_i.request(16'h0000);
		ev(16'h0000, 16'h0000, 1'b0, 1'b1);
		ev(16'h0000, 16'h0000, 1'b0, 1'b1);
		check(gs(), 32'h0000_0004);
		wr(OFS_PRIO_BASE + 8'h3C, 32'h0000_004F);
		run(16'h0004);
		dsp_engine_model_i.request(16'h8000);
		cyc();
		check(gs(), 32'h0000_0024);
		dsp_engine_model_i.request(16'h0000);
		ev(16'h0000, 16'h0000, 1'b0, 1'b1);
		wr(OFS_ENG_CTRL, 32'h0000_0001);
		run(16'h0004);
		dsp_engine_model_i.request(16'h0200);
		cyc();
		check(gs(), 32'h0000_0024);
		dsp_engine_model_i.request(16'h0000);
		ev(16'h0000, 16'h0000, 1'b0, 1'b1);
		wr(OFS_ENG_CTRL, 32'h0000_0000);
		wr(OFS_PRIO_BASE + 8'h04, 32'h0000_0002);
		cyc();
		check(32'(config_err), 32'h0000_0001);
		rd(OFS_ARB_STAT, 32'h0001_0202);
		wr(OFS_PRIO_BASE + 8'h04, 32'h0000_0001);
		cyc();
		check(32'(config_err), 32'h0000_0000);
		$display("arbiter test done");
	endtask : t_arb

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= '0;
		pwdata  <= '0;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		t_reset();
		t_irq();
		t_err();
		t_gpo();
		t_arb();
		report_and_stop();
	end

endmodule : tb
